// ---- core/mpi_map.svh ----
// Purpose: constants for the multiphase pwm interleaver
// Assumes: 20 MHz system clock
// Notes:   all counts in system clock cycles
`ifndef MPI_MAP_SVH
`define MPI_MAP_SVH
`define MPI_CLK_HZ        20000000
`define MPI_FSW_HZ        250000
`define MPI_PERIOD_CYC    (`MPI_CLK_HZ / `MPI_FSW_HZ)
`define MPI_CNT_W         16
`define MPI_DUTY_RST      16'h0020
`define MPI_PH4           2'h0
`define MPI_PH3           2'h1
`define MPI_PH2           2'h2
`endif

// ---- core/mpi_pkg.sv ----
// Purpose: types for the multiphase pwm interleaver
// Assumes: nothing beyond the map header
// Notes:   strap capture state travels as an enum, per-channel edge pair as a struct
package mpi_pkg;
  typedef enum logic [1:0] {MPI_STRAP, MPI_RUN} mpi_state_e;
  typedef struct packed {
    logic [15:0] lead;  // leading edge offset within own cycle
    logic [15:0] trail; // trailing edge offset within own cycle
  } mpi_edges_s;
endpackage

// ---- core/mpi_interleaver.sv ----
// Purpose: interleaved four-channel pwm timing with strap-selected phase count
// Assumes: drive/strap pins are sampled through two flops; one clock, sync reset
// Notes:   analog loop is outside; duty and lead offset arrive as numbers
`timescale 1ns/1ns
`include "mpi_map.svh"

module mpi_interleaver
  import mpi_pkg::*;
#(
  parameter int PERIOD = `MPI_PERIOD_CYC // cycles per switching period
)(
  input  wire logic        clock,                // system clock
  input  wire logic        sys_rst,              // sync reset, active high
  input  wire logic        strap_three_in,       // phase-three pin level
  input  wire logic        strap_four_in,        // phase-four pin level
  input  wire logic [15:0] duty_cycles,          // on-time in cycles
  input  wire logic [15:0] lead_shift,           // leading edge advance, transients
  input  wire logic        dual_edge_modulation, // high lets leading edge move
  input  wire logic        adaptive_all_phase_turn_on, // large step request
  output logic [3:0]       phase_drive_out,      // drive levels, bit0 = phase one
  output logic [3:0]       phase_drive_oe,       // high while driving a phase pin
  output logic [3:0]       channel_current_sense,// per-channel sense enables
  output logic [1:0]       phase_count_code      // latched phase mode
);

  // two-flop synchronisers; first stage read only by second
  // the strap pins are board-level ties that may settle late at power-up,
  // so nothing but the second stage is ever looked at
  logic [1:0] s1_reg, s1_next, s2_reg, s2_next;
  always_comb
  begin
    s1_next = {strap_four_in, strap_three_in};
    s2_next = s1_reg;
  end
  always_ff @(posedge clock)
  begin
    s1_reg <= s1_next;
    s2_reg <= s2_next;
  end

  // strap capture state: one wait after release lets sync flops settle
  // the wait spans four edges; straps must be steady from release on
  mpi_state_e state_reg, state_next;
  logic [1:0] wait_reg, wait_next;
  logic [1:0] mode_reg, mode_next;
  always_comb
  begin
    state_next = state_reg;
    wait_next  = wait_reg;
    mode_next  = mode_reg;
    case (state_reg)
      MPI_STRAP:
      begin
        wait_next = wait_reg + 2'h1;
        if (wait_reg == 2'h3)
        begin
          state_next = MPI_RUN;
          if (s2_reg[0])
            mode_next = `MPI_PH2;
          else if (s2_reg[1])
            mode_next = `MPI_PH3;
          else
            mode_next = `MPI_PH4;
        end
      end
      // straps are ignored from here on, so a pin that later carries
      // a pulse can never change the mode under way
      MPI_RUN:
        state_next = MPI_RUN; // held until next reset
      default:
        state_next = MPI_STRAP;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      state_reg <= MPI_STRAP;
      wait_reg  <= 2'h0;
      mode_reg  <= `MPI_PH4;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      mode_reg  <= mode_next;
    end
  end

  // active channel count; bit mask of live channels
  logic [2:0] nch;
  logic [3:0] live;
  always_comb
  begin
    case (mode_reg)
      `MPI_PH3:
      begin
        nch  = 3'd3; // three channels, phase four idle
        live = 4'h7;
      end
      `MPI_PH2:
      begin
        nch  = 3'd2; // two channels, phases three and four idle
        live = 4'h3;
      end
      default:
      begin
        nch  = 3'd4; // the default count, also catches a stray code
        live = 4'hF;
      end
    endcase
  end

  // master period counter: fixed period regardless of edges
  // edge movement never touches this count, so the repetition rate
  // stays fixed even while both edges shift during a transient
  logic [15:0] cnt_reg, cnt_next;
  always_comb
  begin
    if (state_reg != MPI_RUN || cnt_reg == 16'(PERIOD - 1))
      cnt_next = 16'h0000;
    else
      cnt_next = cnt_reg + 16'h0001;
  end
  always_ff @(posedge clock)
  begin
    if (sys_rst)
      cnt_reg <= 16'h0000;
    else
      cnt_reg <= cnt_next;
  end

  // per-channel phase: channel k (0-based) trails the highest active by
  // (nch-1-k)/nch of the period, giving firing order highest to lowest
  // limitation: offsets truncate when the period is not a multiple of nch
  logic [15:0] slot;
  always_comb
  begin
    case (nch)
      3'd3:    slot = 16'(PERIOD / 3);
      3'd2:    slot = 16'(PERIOD / 2);
      default: slot = 16'(PERIOD / 4);
    endcase
  end

  // clamp edge inputs into a legal window
  // the duty stays below a full period so every pulse without a lead still ends, and a
  // lead longer than the pulse is cut back to keep the edges in order
  logic [15:0] lead_eff, trail_eff;
  always_comb
  begin
    lead_eff  = dual_edge_modulation ? lead_shift : 16'h0000;
    trail_eff = (duty_cycles > 16'(PERIOD - 1)) ? 16'(PERIOD - 1) : duty_cycles;
    if (lead_eff > trail_eff)
      lead_eff = trail_eff;
  end

  // phase pulses; local time t = cnt - offset mod period; the pulse
  // ends at t = trail, so same-channel ends are one period apart
  logic [3:0] drv_reg, drv_next;
  logic [3:0] oe_reg, oe_next;
  logic [3:0] sen_reg, sen_next;
  genvar k;
  generate
    for (k = 0; k < 4; k++)
    begin : g_ch
      logic [15:0] off, t, start;
      logic [31:0] prod;
      always_comb
      begin
        prod  = 32'(slot) * 32'(nch - 3'd1 - 3'(k));
        off   = prod[15:0];
        t     = (cnt_reg >= off) ? cnt_reg - off : cnt_reg + 16'(PERIOD) - off;
        // leading edge moves only while transient shift given
        start = (lead_eff == 16'h0000) ? 16'h0000 : 16'(PERIOD) - lead_eff;
        if (!live[k] || state_reg != MPI_RUN)
          drv_next[k] = 1'b0;
        else if (adaptive_all_phase_turn_on)
          drv_next[k] = 1'b1; // all live phases together on a big step
        else
          drv_next[k] = (t < trail_eff) || (start != 16'h0000 && t >= start);
        oe_next[k]  = live[k] && state_reg == MPI_RUN; // unused pins undriven
        sen_next[k] = live[k] && state_reg == MPI_RUN;
      end
    end
  endgenerate
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      drv_reg <= 4'h0;
      oe_reg  <= 4'h0;
      sen_reg <= 4'h0;
    end
    else
    begin
      drv_reg <= drv_next;
      oe_reg  <= oe_next;
      sen_reg <= sen_next;
    end
  end

  // outputs straight from flops
  // the drive pins stay released until the straps are latched, so a
  // strapped pin is never fought while it is being read
  assign phase_drive_out       = drv_reg;
  assign phase_drive_oe        = oe_reg;
  assign channel_current_sense = sen_reg;
  assign phase_count_code      = mode_reg;

endmodule

// ---- testbench/mpi_checker.sv ----
// Purpose: port checks for the pwm interleaver
// Assumes: duty held steady while edges are judged
// Notes:   a large-step request pauses the edge checks
`timescale 1ns/1ns
module mpi_checker #(
  parameter int PERIOD = 12 // cycles per period
)(
  input wire logic       clock,                      // system clock
  input wire logic       sys_rst,                    // sync reset
  input wire logic       adaptive_all_phase_turn_on, // step request
  input wire logic [3:0] phase_drive_out,            // drive levels
  input wire logic [3:0] phase_drive_oe,             // drive enables
  input wire logic [3:0] channel_current_sense,      // sense enables
  input wire logic [1:0] phase_count_code            // latched mode
);
  localparam int Q4 = PERIOD / 4; // quarter gap
  localparam int Q3 = PERIOD / 3; // third gap
  localparam int Q2 = PERIOD / 2; // half gap
  localparam int QP = PERIOD;     // own period
  wire [3:0] o = phase_drive_out;
  wire [3:0] e = phase_drive_oe;
  wire [1:0] m = phase_count_code;
  // a forced turn-on adds edges, so edge checks pause while it is asked
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst || adaptive_all_phase_turn_on);
  sequence s_end(int k); $fell(o[k]); endsequence // pulse termination
  a_mode_held: assert property (|e |=> $stable(m))
    else $error("mode changed");
  a_live_set: assert property (|e |-> channel_current_sense == e &&
    e == (m[1] ? 4'h3 : m[0] ? 4'h7 : 4'hF)) else $error("live set wrong");
  a_drive_gated: assert property ((o & ~e) == 4'h0)
    else $error("undriven pin moves");
  a_all_on: assert property (disable iff (sys_rst)
    adaptive_all_phase_turn_on && |e |=> (o & e) == e) else $error("no joint turn-on");
  a_pulse_period: assert property (s_end(0) |-> ##QP s_end(0))
    else $error("period off");
  a_four_gap: assert property (m == 2'h0 ##0 s_end(3) |-> ##Q4 s_end(2))
    else $error("four-phase gap off");
  a_three_gap: assert property (m == 2'h1 ##0 s_end(2) |-> ##Q3 s_end(1))
    else $error("three-phase gap off");
  a_two_gap: assert property (m == 2'h2 ##0 s_end(1) |-> ##Q2 s_end(0))
    else $error("two-phase gap off");
endmodule
bind mpi_interleaver mpi_checker #(.PERIOD(PERIOD)) u_chk (.clock(clock), .sys_rst(sys_rst),
  .adaptive_all_phase_turn_on(adaptive_all_phase_turn_on), .phase_drive_out(phase_drive_out),
  .phase_drive_oe(phase_drive_oe), .channel_current_sense(channel_current_sense),
  .phase_count_code(phase_count_code));

// ---- testbench/mpi_gate_model.sv ----
// Purpose: gate drivers and strap ties on the phase pins
// Assumes: a strapped pin reads high once released
// Notes:   unstrapped released pins sit at the pull-down
`timescale 1ns/1ns
module mpi_gate_model (
  input  wire logic [3:0] drive, // pwm levels
  input  wire logic [3:0] oe,    // pin driven
  input  wire logic [1:0] tie,   // pin three, pin four tied high
  output logic      [3:0] pad    // resolved pin levels
);
  // pin level from the controller's enable, else the tie on pins three and four
  always_comb
  begin
    pad = drive & oe;
    pad[2] = oe[2] ? drive[2] : tie[0];
    pad[3] = oe[3] ? drive[3] : tie[1];
  end
endmodule

// ---- testbench/mpi_interleaver_tb.sv ----
// Purpose: directed run of the pwm interleaver in each phase mode
// Assumes: short period of 12 cycles, duty of 2
// Notes:   the joint turn-on stays asked until the run ends
`timescale 1ns/1ns
module mpi_interleaver_tb;
  localparam int P = 12;
  logic        clock = 0, sys_rst = 1, dual = 0, step_req = 0;
  logic [1:0]  tie = 0, code;
  logic [15:0] duty = 16'h0002, lead = 16'h0000;
  logic [3:0]  out, oe, sense, pad;
  int          fail_count = 0, checks = 0;
  mpi_interleaver #(.PERIOD(P)) uut (.clock(clock), .sys_rst(sys_rst),
    .strap_three_in(pad[2]), .strap_four_in(pad[3]), .duty_cycles(duty), .lead_shift(lead),
    .dual_edge_modulation(dual), .adaptive_all_phase_turn_on(step_req), .phase_drive_out(out),
    .phase_drive_oe(oe), .channel_current_sense(sense), .phase_count_code(code));
  mpi_gate_model pm (.drive(out), .oe(oe), .tie(tie), .pad(pad));
  initial forever #25 clock = ~clock;
  task chk(string n, logic [3:0] e, logic [3:0] s);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  // reset with a strap, judge the mode, then move the strap: it must not count
  task run_mode(logic [1:0] t, logic [1:0] c, logic [3:0] live);
    @(posedge clock);
    tie <= t;
    sys_rst <= 1'b1;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (3 * P) @(posedge clock);
    #1 chk("code", {2'h0, c}, {2'h0, code});
    chk("oe", live, oe);
    chk("sense", live, sense);
    @(posedge clock);
    tie <= ~t;
    repeat (P) @(posedge clock);
    #1 chk("held", {2'h0, c}, {2'h0, code});
  endtask
  // count phase-one high cycles over one full period, sampled once settled
  task width(logic [3:0] exp);
    logic [3:0] n;
    n = 4'h0;
    repeat (P)
    begin
      @(posedge clock);
      #1 n = n + {3'h0, pad[0]};
    end
    chk("width", exp, n);
  endtask
  // steady trailing-edge width, then a leading-edge advance of two
  task edge_widths;
    width(4'h2);
    @(posedge clock);
    dual <= 1'b1;
    lead <= 16'h0002;
    repeat (P) @(posedge clock);
    width(4'h4);
  endtask
  // a large step forces every live phase on
  task all_phase_step(logic [3:0] live);
    @(posedge clock);
    step_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("all on", live, out);
  endtask
  task complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    run_mode(2'h0, 2'h0, 4'hF);
    edge_widths;
    run_mode(2'h2, 2'h1, 4'h7);
    run_mode(2'h1, 2'h2, 4'h3);
    all_phase_step(4'h3);
    complete_run;
  end
  // cut a hang well past the expected few hundred cycles
  initial
  begin
    repeat (1000) @(posedge clock);
    fail_count++;
    complete_run;
  end
endmodule
